// ===== hw/acm_pkg.sv
// Constants and types for the audio clock monitor status block
package acm_pkg;
  localparam int          CLK_HZ         = 250_000_000;
  // Register offsets
  localparam logic [7:0]  ADDR_RATIO_HI  = 8'h5C;
  localparam logic [7:0]  ADDR_RATIO_LO  = 8'h5D;
  localparam logic [7:0]  ADDR_DET_STAT  = 8'h5E;
  localparam logic [7:0]  ADDR_ERR_FLAGS = 8'h5F;
  localparam logic [7:0]  ADDR_MUTE_MON  = 8'h6C;
  // Field positions
  localparam int          BIT_MCLK_MISS  = 6;
  localparam int          BIT_PLL_UNLK   = 5;
  localparam int          BIT_FB_ABSENT  = 4;
  localparam int          BIT_COMBO_ERR  = 3;
  localparam int          BIT_MCLK_INV   = 2;
  localparam int          BIT_BCLK_INV   = 1;
  localparam int          BIT_RATE_INV   = 0;
  localparam int          BIT_HALT_LAT   = 4;
  localparam int          BIT_ABSENT_LIV = 2;
  localparam int          BIT_RESYNC     = 1;
  localparam int          BIT_ERR_LAT    = 0;
  localparam int          BIT_MUTE_L     = 1;
  localparam int          BIT_MUTE_R     = 0;
  localparam logic [7:0]  RESET_BYTE     = 8'h00;
  // Monitored clock lanes
  localparam int          NUM_CLK        = 3;
  localparam int          LANE_MCLK      = 0;
  localparam int          LANE_BCLK      = 1;
  localparam int          LANE_FCLK      = 2;
  // Limits
  localparam logic [8:0]  BCLK_MIN       = 9'h020;
  localparam logic [8:0]  BCLK_MAX       = 9'h100;
  localparam logic [7:0]  LOW_BITS_MIN   = 8'h05;
  localparam logic [11:0] MCLK_DSP_MIN   = 12'h080;
  localparam int          FS_MAX_HZ      = 384_000;
  localparam int          FS_MIN_HZ      = 8_000;
  localparam logic [15:0] FS_MIN_CYC     = 16'(CLK_HZ / FS_MAX_HZ);
  localparam logic [15:0] FS_MAX_CYC     = 16'(CLK_HZ / FS_MIN_HZ);
  // Times
  localparam int          MISS_TIME_NS   = 1000;
  localparam int          RESYNC_TIME_NS = 2000;
  localparam logic [9:0]  MISS_CYC       = 10'(MISS_TIME_NS / (1_000_000_000 / CLK_HZ));
  localparam logic [9:0]  RESYNC_CYC     = 10'(RESYNC_TIME_NS / (1_000_000_000 / CLK_HZ));
  typedef enum logic [1:0] {SYNC_OK, SYNC_ERR, SYNC_RESYNC} acm_sync_t;
endpackage : acm_pkg

// ===== hw/acm_clk_if.sv
// Carrier of sampled clock events between the monitor top and its ratio counter
`timescale 1ns/1ps
interface acm_clk_if;
  import acm_pkg::*;
  logic [NUM_CLK-1:0] rise;
  logic [NUM_CLK-1:0] level;
  logic [NUM_CLK-1:0] present;
  modport src (output rise, output level, output present);
  modport snk (input rise, input level, input present);
endinterface : acm_clk_if

// ===== hw/acm_edge.sv
// Edge and activity detector for one sampled clock pin
`timescale 1ns/1ps
module acm_edge
  import acm_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic pin_i,
  output logic      rise_o,
  output logic      level_o,
  output logic      present_o
);
  logic       lvl_ff,  nxt_lvl;
  logic [9:0] idle_ff, nxt_idle;

  always_comb begin
    nxt_lvl  = pin_i;
    nxt_idle = idle_ff;
    if (pin_i && !lvl_ff) begin
      nxt_idle = 10'h000;
    end else if (idle_ff < MISS_CYC) begin
      nxt_idle = idle_ff + 10'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lvl_ff  <= 1'b0;
      idle_ff <= MISS_CYC;
    end else begin
      lvl_ff  <= nxt_lvl;
      idle_ff <= nxt_idle;
    end
  end

  assign rise_o    = pin_i && !lvl_ff;
  assign level_o   = lvl_ff;
  // Saturating idle count: no rise within the window means the clock is gone
  assign present_o = idle_ff < MISS_CYC;
endmodule : acm_edge

// ===== hw/acm_ratio.sv
// Per-frame counters: bit clocks, master clocks, frame period and frame low time
`timescale 1ns/1ps
module acm_ratio
  import acm_pkg::*;
(
  input  wire logic  clk_i,
  input  wire logic  rst_i,
  acm_clk_if.snk     ck,
  output logic [8:0]  bit_ratio_o,
  output logic        bit_stable_o,
  output logic [11:0] mclk_ratio_o,
  output logic [15:0] period_o,
  output logic [7:0]  low_bits_o
);
  logic [8:0]  bcnt_ff,  nxt_bcnt,  bres_ff,  nxt_bres;
  logic [11:0] mcnt_ff,  nxt_mcnt,  mres_ff,  nxt_mres;
  logic [15:0] pcnt_ff,  nxt_pcnt,  pres_ff,  nxt_pres;
  logic [7:0]  lcnt_ff,  nxt_lcnt,  lres_ff,  nxt_lres;
  logic        stab_ff,  nxt_stab;
  logic        frame;

  assign frame = ck.rise[LANE_FCLK];

  always_comb begin
    nxt_bcnt = bcnt_ff;
    nxt_mcnt = mcnt_ff;
    nxt_pcnt = pcnt_ff;
    nxt_lcnt = lcnt_ff;
    nxt_bres = bres_ff;
    nxt_mres = mres_ff;
    nxt_pres = pres_ff;
    nxt_lres = lres_ff;
    nxt_stab = stab_ff;
    if (frame) begin
      // Count of bit clocks within the finished frame
      // A single frame gives no trustworthy count: stable only when two successive frames agree
      nxt_bres = bcnt_ff;
      nxt_mres = mcnt_ff;
      nxt_pres = pcnt_ff;
      nxt_lres = lcnt_ff;
      nxt_stab = (bcnt_ff == bres_ff);
      nxt_bcnt = 9'(ck.rise[LANE_BCLK]);
      nxt_mcnt = 12'(ck.rise[LANE_MCLK]);
      nxt_pcnt = 16'h0001;
      nxt_lcnt = 8'h00;
    end else begin
      // Counters saturate so a missing frame clock cannot wrap them
      if (ck.rise[LANE_BCLK] && bcnt_ff != 9'h1FF) nxt_bcnt = bcnt_ff + 9'h001;
      if (ck.rise[LANE_MCLK] && mcnt_ff != 12'hFFF) nxt_mcnt = mcnt_ff + 12'h001;
      if (pcnt_ff != 16'hFFFF) nxt_pcnt = pcnt_ff + 16'h0001;
      if (ck.rise[LANE_BCLK] && !ck.level[LANE_FCLK] && lcnt_ff != 8'hFF) begin
        nxt_lcnt = lcnt_ff + 8'h01;
      end
    end
    // Frame loss is judged by the period counter: slow frames outlast the pin idle
    // window, which would otherwise keep the ratio marked unstable for good
    if (pcnt_ff == 16'hFFFF) nxt_stab = 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bcnt_ff <= 9'h000;
      mcnt_ff <= 12'h000;
      pcnt_ff <= 16'h0000;
      lcnt_ff <= 8'h00;
      bres_ff <= 9'h000;
      mres_ff <= 12'h000;
      pres_ff <= 16'h0000;
      lres_ff <= 8'h00;
      stab_ff <= 1'b0;
    end else begin
      bcnt_ff <= nxt_bcnt;
      mcnt_ff <= nxt_mcnt;
      pcnt_ff <= nxt_pcnt;
      lcnt_ff <= nxt_lcnt;
      bres_ff <= nxt_bres;
      mres_ff <= nxt_mres;
      pres_ff <= nxt_pres;
      lres_ff <= nxt_lres;
      stab_ff <= nxt_stab;
    end
  end

  assign bit_ratio_o  = bres_ff;
  assign bit_stable_o = stab_ff;
  assign mclk_ratio_o = mres_ff;
  assign period_o     = pres_ff;
  assign low_bits_o   = lres_ff;

  chk_ratio_capture: assert property (@(posedge clk_i) disable iff (rst_i)
    frame |=> bres_ff == $past(bcnt_ff)) else $error("bit ratio not captured at frame");
endmodule : acm_ratio

// ===== hw/acm_monitor.sv
// Clock monitor status block: detects audio clock health, serves status registers
`timescale 1ns/1ps
module acm_monitor
  import acm_pkg::*;
(
  // Clock and reset
  input  wire logic       CLK_I,
  input  wire logic       SYS_RST_I,
  // Audio clocks from the serial host, sampled
  input  wire logic       MST_CLK_I,
  input  wire logic       BIT_CLK_I,
  input  wire logic       FRM_CLK_I,
  // PLL and configuration
  input  wire logic       PLL_EN_I,
  input  wire logic       PLL_LOCK_I,
  input  wire logic       ERROR_IGNORE_CONFIG_I,
  // Analog mute state, high while muted
  input  wire logic       MUTE_L_I,
  input  wire logic       MUTE_R_I,
  // Register read port
  input  wire logic       REG_RD_I,
  input  wire logic [7:0] REG_ADDR_I,
  output logic [7:0]      REG_RDATA_O
);
  import acm_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // Clock sampling and per-frame counting
  acm_clk_if ck ();
  logic [NUM_CLK-1:0] pins;
  assign pins = {FRM_CLK_I, BIT_CLK_I, MST_CLK_I};

  genvar g;
  generate
    for (g = 0; g < NUM_CLK; g++) begin : g_edge
      acm_edge u_edge (
        .clk_i     (CLK_I),
        .rst_i     (SYS_RST_I),
        .pin_i     (pins[g]),
        .rise_o    (ck.rise[g]),
        .level_o   (ck.level[g]),
        .present_o (ck.present[g])
      );
    end
  endgenerate

  logic [8:0]  bit_ratio_count;
  logic        bit_stable;
  logic [11:0] mclk_ratio;
  logic [15:0] frame_period;
  logic [7:0]  frame_low_bits;

  acm_ratio u_ratio (
    .clk_i        (CLK_I),
    .rst_i        (SYS_RST_I),
    .ck           (ck),
    .bit_ratio_o  (bit_ratio_count),
    .bit_stable_o (bit_stable),
    .mclk_ratio_o (mclk_ratio),
    .period_o     (frame_period),
    .low_bits_o   (frame_low_bits)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding
  function automatic logic mclk_ratio_ok(input logic [11:0] r);
    unique case (r)
      12'h020, 12'h030, 12'h040, 12'h080, 12'h0C0, 12'h100, 12'h180,
      12'h200, 12'h300, 12'h400, 12'h480, 12'h600, 12'h800: mclk_ratio_ok = 1'b1;
      default: mclk_ratio_ok = 1'b0;
    endcase
  endfunction : mclk_ratio_ok

  function automatic logic in_range16(input logic [15:0] v, input logic [15:0] lo,
                                      input logic [15:0] hi);
    in_range16 = (v >= lo) && (v <= hi);
  endfunction : in_range16

  ////////////////////////////////////////////////////////////////////////////////
  // Live status
  logic master_clock_missing, pll_unlocked, frame_and_bit_clock_absent;
  logic autoset_combo_error, master_clock_invalid, bit_clock_invalid;
  logic rate_bad_raw, sample_rate_invalid, clock_error_now;

  always_comb begin
    master_clock_missing       = !ck.present[LANE_MCLK];
    pll_unlocked               = !PLL_EN_I || !PLL_LOCK_I;
    frame_and_bit_clock_absent = !ck.present[LANE_FCLK] && !ck.present[LANE_BCLK]
                                 && !ck.level[LANE_FCLK] && !ck.level[LANE_BCLK];
    master_clock_invalid       = master_clock_missing || !mclk_ratio_ok(mclk_ratio)
                                 || (frame_low_bits <= LOW_BITS_MIN);
    bit_clock_invalid          = !bit_stable || frame_and_bit_clock_absent
                                 || (bit_ratio_count < BCLK_MIN)
                                 || (bit_ratio_count > BCLK_MAX);
    rate_bad_raw               = frame_and_bit_clock_absent
                                 || !in_range16(frame_period, FS_MIN_CYC, FS_MAX_CYC);
    // Ignored errors let the converter run, so the flag drops with it
    sample_rate_invalid        = rate_bad_raw && !ERROR_IGNORE_CONFIG_I;
    // Without the PLL the master clock alone must give enough DSP cycles
    autoset_combo_error        = rate_bad_raw || master_clock_invalid
                                 || (!PLL_EN_I && (mclk_ratio < MCLK_DSP_MIN));
    clock_error_now            = master_clock_missing || autoset_combo_error
                                 || bit_clock_invalid || sample_rate_invalid;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Resynchronisation sequencer and latched flags
  acm_sync_t  sync_ff, nxt_sync;
  logic [9:0] rs_cnt_ff, nxt_rs_cnt;
  logic       halt_ff, nxt_halt, err_ff, nxt_err;
  logic       rd_flags;

  assign rd_flags = REG_RD_I && (REG_ADDR_I == ADDR_ERR_FLAGS);

  always_comb begin
    nxt_sync   = sync_ff;
    nxt_rs_cnt = rs_cnt_ff;
    unique case (sync_ff)
      SYNC_OK: begin
        if (clock_error_now) nxt_sync = SYNC_ERR;
      end
      SYNC_ERR: begin
        if (!clock_error_now) begin
          nxt_sync   = SYNC_RESYNC;
          nxt_rs_cnt = RESYNC_CYC;
        end
      end
      SYNC_RESYNC: begin
        if (clock_error_now) begin
          nxt_sync = SYNC_ERR;
        end else if (rs_cnt_ff == 10'h001) begin
          nxt_sync = SYNC_OK;
        end
        nxt_rs_cnt = rs_cnt_ff - 10'h001;
      end
    endcase
    // A new event outranks the clearing read
    nxt_halt = master_clock_missing || (halt_ff && !rd_flags);
    nxt_err  = clock_error_now || (err_ff && !rd_flags);
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      sync_ff   <= SYNC_OK;
      rs_cnt_ff <= 10'h000;
      halt_ff   <= 1'b0;
      err_ff    <= 1'b0;
    end else begin
      sync_ff   <= nxt_sync;
      rs_cnt_ff <= nxt_rs_cnt;
      halt_ff   <= nxt_halt;
      err_ff    <= nxt_err;
    end
  end

  logic resync_in_progress;
  assign resync_in_progress = (sync_ff == SYNC_RESYNC);

  ////////////////////////////////////////////////////////////////////////////////
  // Register read mux
  logic [7:0] rdata_ff, nxt_rdata;

  always_comb begin
    nxt_rdata = RESET_BYTE;
    if (REG_RD_I) begin
      unique case (REG_ADDR_I)
        ADDR_RATIO_HI: nxt_rdata[0] = bit_ratio_count[8];
        ADDR_RATIO_LO: nxt_rdata    = bit_ratio_count[7:0];
        ADDR_DET_STAT: begin
          nxt_rdata[BIT_MCLK_MISS] = master_clock_missing;
          nxt_rdata[BIT_PLL_UNLK]  = pll_unlocked;
          nxt_rdata[BIT_FB_ABSENT] = frame_and_bit_clock_absent;
          nxt_rdata[BIT_COMBO_ERR] = autoset_combo_error;
          nxt_rdata[BIT_MCLK_INV]  = master_clock_invalid;
          nxt_rdata[BIT_BCLK_INV]  = bit_clock_invalid;
          nxt_rdata[BIT_RATE_INV]  = sample_rate_invalid;
        end
        ADDR_ERR_FLAGS: begin
          nxt_rdata[BIT_HALT_LAT]   = halt_ff;
          nxt_rdata[BIT_ABSENT_LIV] = frame_and_bit_clock_absent;
          nxt_rdata[BIT_RESYNC]     = resync_in_progress;
          nxt_rdata[BIT_ERR_LAT]    = err_ff;
        end
        ADDR_MUTE_MON: begin
          nxt_rdata[BIT_MUTE_L] = !MUTE_L_I;
          nxt_rdata[BIT_MUTE_R] = !MUTE_R_I;
        end
        default: nxt_rdata = RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge CLK_I) begin
    if (SYS_RST_I) begin
      rdata_ff <= RESET_BYTE;
    end else begin
      rdata_ff <= nxt_rdata;
    end
  end

  assign REG_RDATA_O = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (SYS_RST_I);

  chk_ratio_lo_read: assert property (
    REG_RD_I && REG_ADDR_I == ADDR_RATIO_LO |=> REG_RDATA_O == $past(bit_ratio_count[7:0]))
    else $error("ratio low byte read mismatch");
  chk_ratio_hi_read: assert property (
    REG_RD_I && REG_ADDR_I == ADDR_RATIO_HI
    |=> REG_RDATA_O == {7'h00, $past(bit_ratio_count[8])})
    else $error("ratio msb read mismatch");
  chk_mclk_missing: assert property (
    !ck.present[LANE_MCLK] && REG_RD_I && REG_ADDR_I == ADDR_DET_STAT
    |=> REG_RDATA_O[BIT_MCLK_MISS]) else $error("master clock missing not shown");
  chk_pll_disabled: assert property (
    !PLL_EN_I && REG_RD_I && REG_ADDR_I == ADDR_DET_STAT |=> REG_RDATA_O[BIT_PLL_UNLK])
    else $error("disabled pll not reported unlocked");
  chk_absent_both: assert property (
    $rose(BIT_CLK_I) || $rose(FRM_CLK_I) |=> !frame_and_bit_clock_absent)
    else $error("absent flag with a clock present");
  chk_combo_follow: assert property (
    master_clock_invalid |-> autoset_combo_error) else $error("combo error missed");
  chk_low_period: assert property (
    frame_low_bits <= LOW_BITS_MIN |-> master_clock_invalid)
    else $error("short frame low period not flagged");
  chk_bclk_range: assert property (
    !bit_clock_invalid |-> bit_stable && bit_ratio_count >= BCLK_MIN
    && bit_ratio_count <= BCLK_MAX) else $error("bit clock valid out of range");
  chk_rate_ignore: assert property (
    ERROR_IGNORE_CONFIG_I && REG_RD_I && REG_ADDR_I == ADDR_DET_STAT
    |=> !REG_RDATA_O[BIT_RATE_INV]) else $error("rate flag despite ignore");
  chk_halt_clear: assert property (
    rd_flags && !master_clock_missing |=> !halt_ff) else $error("halt flag not cleared");
  chk_halt_sticky: assert property (
    halt_ff && !rd_flags |=> halt_ff) else $error("halt flag lost without read");
  chk_resync_len: assert property (
    $rose(resync_in_progress) && !clock_error_now ##1 !clock_error_now [*8]
    |-> resync_in_progress) else $error("resync ended early");
  chk_err_set_wins: assert property (
    clock_error_now && rd_flags |=> err_ff) else $error("error lost at clearing read");
  chk_err_clear: assert property (
    rd_flags && !clock_error_now |=> !err_ff) else $error("error flag not cleared");
  chk_mute_map: assert property (
    REG_RD_I && REG_ADDR_I == ADDR_MUTE_MON && MUTE_L_I |=> !REG_RDATA_O[BIT_MUTE_L])
    else $error("left mute not shown as 0");

  cov_halt_read:  cover property (halt_ff ##1 rd_flags);
  cov_resync_end: cover property (resync_in_progress ##1 !resync_in_progress);
  cov_clock_good: cover property (!clock_error_now && bit_ratio_count == 9'h040);
  cov_absent:     cover property (frame_and_bit_clock_absent);
endmodule : acm_monitor

// ===== test/acm_host_model.sv
// Behavioural serial audio host: master, bit and frame clocks as sampled levels
`timescale 1ns/1ps
module acm_host_model (
  // Clock
  input  wire logic       clk_i,
  // Clock enables and frame shape
  input  wire logic       mclk_en_i,
  input  wire logic       frm_en_i,
  input  wire logic [8:0] bits_i,
  input  wire logic [8:0] low_i,
  // Sampled clock levels
  output logic            mclk_o,
  output logic            bclk_o,
  output logic            fclk_o
);
  logic [1:0]  mcyc;
  logic [12:0] cyc;
  initial begin
    mcyc   = '0;
    cyc    = '0;
    mclk_o = 1'b0;
    bclk_o = 1'b0;
    fclk_o = 1'b0;
  end
  //////////////////////////////////////////////////////////////////////////////////////////
  // Pins move at the falling edge so the monitor always samples settled levels.
  // Master clock period is 4 system cycles, a bit lasts 16, so master ratio = 4 x bits.
  always @(negedge clk_i) begin
    mcyc   <= mcyc + 2'd1;
    mclk_o <= mclk_en_i & mcyc[1]; // Halted master clock stands low
    if (!frm_en_i) begin
      cyc    <= '0;
      bclk_o <= 1'b0; // Both held low while frames are disabled
      fclk_o <= 1'b0;
    end else begin
      cyc    <= (cyc >= {bits_i, 4'h0} - 13'd1) ? '0 : cyc + 13'd1;
      bclk_o <= (cyc[3:0] < 4'd8);
      // Frame edges move on bit clock falls, so the low half holds exactly low_i bit rises
      if (cyc[3:0] == 4'd8) begin
        fclk_o <= ((cyc[12:4] == bits_i - 9'd1) ? 9'd0 : cyc[12:4] + 9'd1) < bits_i - low_i;
      end
    end
  end
endmodule : acm_host_model

// ===== test/tb_top.sv
// Self-checking bench for the audio clock monitor status block
`timescale 1ns/1ps
module tb_top;
  import acm_pkg::*;
  logic        clk, rst, pll_en, pll_lock, ign, mute_l, mute_r, rd, pend;
  logic        mclk_on, frm_on;
  logic [7:0]  addr;
  logic [7:0]  rdata;
  logic [8:0]  bits, lowb;
  logic [31:0] lfsr;
  logic [15:0] expq[$];
  wire logic   mclk, bclk, fclk;
  int          n_fail, cmp_count;

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////////////////////
  acm_host_model i_acm_host_model (.clk_i(clk), .mclk_en_i(mclk_on), .frm_en_i(frm_on),
    .bits_i(bits), .low_i(lowb), .mclk_o(mclk), .bclk_o(bclk), .fclk_o(fclk));
  acm_monitor i_acm_monitor (.CLK_I(clk), .SYS_RST_I(rst), .MST_CLK_I(mclk), .BIT_CLK_I(bclk),
    .FRM_CLK_I(fclk), .PLL_EN_I(pll_en), .PLL_LOCK_I(pll_lock), .ERROR_IGNORE_CONFIG_I(ign),
    .MUTE_L_I(mute_l), .MUTE_R_I(mute_r), .REG_RD_I(rd), .REG_ADDR_I(addr),
    .REG_RDATA_O(rdata));
  //////////////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : lfsr_next

  // Combo error reading is only compared with the error-ignore input low
  function automatic logic [7:0] exp_stat();
    int   p, m;
    logic rb, mi;
    p  = 16 * int'(bits);
    m  = 4 * int'(bits);
    rb = !frm_on || p < int'(FS_MIN_CYC) || p > int'(FS_MAX_CYC);
    mi = !mclk_on || !frm_on || lowb <= 9'(LOW_BITS_MIN) ||
         !(m inside {32, 48, 64, 128, 192, 256, 384, 512, 768, 1024, 1152, 1536, 2048});
    return {1'b0, !mclk_on, !(pll_en && pll_lock), !frm_on, rb || mi || (!pll_en && m < 128),
            mi, !frm_on || bits < BCLK_MIN || bits > BCLK_MAX, rb && !ign};
  endfunction : exp_stat

  task automatic chk(input logic [7:0] got, input logic [15:0] note);
    cmp_count++;
    if ((got & note[7:0]) !== (note[15:8] & note[7:0])) begin
      n_fail++;
      $display("MISMATCH at %0t: read %h expected %h mask %h", $time, got, note[15:8],
               note[7:0]);
    end
  endtask : chk

  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
    @(negedge clk);
    rd   = 1'b1;
    addr = a;
    expq.push_back({e, m});
    @(negedge clk);
    rd   = 1'b0;
  endtask : rd_reg

  // Four frame periods to publish a stable ratio, then room for the resync time
  task automatic settle();
    repeat (4 * 16 * int'(bits) + 600) @(negedge clk);
  endtask : settle

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : final_report
  //////////////////////////////////////////////////////////////////////////////////////////
  // Read data is registered: the old value seen at the next edge is the answer
  always @(posedge clk) begin
    if (pend) chk(rdata, expq.pop_front());
    pend <= rd && !rst;
  end

  initial begin
    repeat (90000) @(posedge clk);
    n_fail++;
    final_report();
  end
  //////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    {rst, pll_en, pll_lock, mclk_on, frm_on} = 5'h1F;
    {ign, mute_l, mute_r, rd, pend} = 5'h00;
    addr = 8'h00;
    bits = 9'd64;
    lowb = 9'd32;
    lfsr = 32'h000E;
    n_fail = 0;
    cmp_count = 0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    rd_reg(8'h60, 8'h00, 8'hFF); // Unmapped offset reads zero
    settle();
    rd_reg(ADDR_DET_STAT, exp_stat(), 8'hFF);
    rd_reg(ADDR_RATIO_LO, 8'h40, 8'hFF);
    rd_reg(ADDR_RATIO_HI, 8'h00, 8'hFF);
    rd_reg(ADDR_ERR_FLAGS, 8'h00, 8'hEE);
    rd_reg(ADDR_ERR_FLAGS, 8'h00, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      @(negedge clk);
      {pll_en, pll_lock} = 2'(i);
      {mute_l, mute_r} = 2'(i);
      repeat (4) @(negedge clk);
      rd_reg(ADDR_DET_STAT, exp_stat(), 8'hFF);
      rd_reg(ADDR_MUTE_MON, {6'h00, ~mute_l, ~mute_r}, 8'hFF);
    end
    bits = 9'd256;
    lowb = 9'd128;
    settle();
    rd_reg(ADDR_RATIO_LO, 8'h00, 8'hFF);
    rd_reg(ADDR_RATIO_HI, 8'h01, 8'hFF);
    rd_reg(ADDR_DET_STAT, exp_stat(), 8'hFF);
    bits = 9'd48;
    for (int i = 5; i < 7; i++) begin
      lowb = 9'(i);
      settle();
      rd_reg(ADDR_DET_STAT, exp_stat(), 8'hFF);
    end
    bits = 9'd16;
    lowb = 9'd8;
    settle();
    rd_reg(ADDR_DET_STAT, exp_stat(), 8'hFF);
    ign = 1'b1;
    repeat (4) @(negedge clk);
    rd_reg(ADDR_DET_STAT, exp_stat(), 8'h01);
    ign = 1'b0;
    for (int i = 0; i < 2; i++) begin
      lfsr = lfsr_next(lfsr);
      bits = 9'(lfsr[6:0]) + 9'd32;
      lowb = bits >> 1;
      settle();
      rd_reg(ADDR_RATIO_LO, bits[7:0], 8'hFF);
      rd_reg(ADDR_RATIO_HI, {7'h00, bits[8]}, 8'hFF);
      rd_reg(ADDR_DET_STAT, exp_stat(), 8'hFF);
    end
    bits = 9'd64;
    lowb = 9'd32;
    settle();
    rd_reg(ADDR_ERR_FLAGS, 8'h00, 8'hEE);
    rd_reg(ADDR_ERR_FLAGS, 8'h00, 8'hFF);
    mclk_on = 1'b0;
    repeat (3000) @(negedge clk);
    rd_reg(ADDR_DET_STAT, exp_stat(), 8'h4C);
    rd_reg(ADDR_ERR_FLAGS, 8'h11, 8'h15);
    rd_reg(ADDR_ERR_FLAGS, 8'h11, 8'h15);
    mclk_on = 1'b1;
    settle();
    rd_reg(ADDR_ERR_FLAGS, 8'h11, 8'hFF);
    rd_reg(ADDR_ERR_FLAGS, 8'h00, 8'hFF);
    frm_on = 1'b0;
    repeat (300) @(negedge clk);
    rd_reg(ADDR_DET_STAT, 8'h10, 8'h50);
    rd_reg(ADDR_ERR_FLAGS, 8'h05, 8'h15);
    frm_on = 1'b1;
    settle();
    rd_reg(ADDR_ERR_FLAGS, 8'h01, 8'hFF);
    rd_reg(ADDR_ERR_FLAGS, 8'h00, 8'hFF);
    repeat (4) @(negedge clk);
    final_report();
  end
endmodule : tb_top
